/* File: logic/pls_pkg.sv */
package pls_pkg;
    // Avalon-MM byte addresses of the register words.
    localparam logic [4:0] PLS_CTRL_ADDR   = 5'h00;
    localparam logic [4:0] PLS_STATUS_ADDR = 5'h04;
    localparam logic [4:0] PLS_CELL_ADDR   = 5'h08;
    localparam logic [4:0] PLS_PROG_ADDR   = 5'h0c;
    localparam logic [4:0] PLS_PCNT_ADDR   = 5'h10;
    // CTRL fields.
    localparam int PLS_CTRL_GNET_LSB  = 0;
    localparam int PLS_CTRL_PROBE_BIT = 4;
    localparam int PLS_CTRL_SEL_LSB   = 8;
    // STATUS fields.
    localparam int PLS_ST_RUN_BIT  = 0;
    localparam int PLS_ST_REJ_BIT  = 1;
    localparam int PLS_ST_LOCK_BIT = 2;
    localparam int PLS_ST_PDEF_BIT = 3;
    localparam int PLS_ST_DEAD_BIT = 4;
    // Reset values.
    localparam logic [15:0] PLS_CTRL_RST = 16'h0000;
    localparam logic [3:0]  PLS_CELL_RST = 4'h0;
    // Number of global networks and demonstration fabric cells.
    localparam int PLS_NETS = 4;
    // Boundary-scan codes at or above this value are programming instructions.
    localparam logic [3:0] PLS_TAP_PRIV_FIRST = 4'h8;
    // Power-up initialisation pulse on the global lines.
    localparam int CLK_MHZ      = 25;
    localparam int INIT_NS      = 200;
    localparam int INIT_CYCLES  = (INIT_NS * CLK_MHZ + 999) / 1000;
    localparam logic [3:0] INIT_LAST = 4'(INIT_CYCLES - 1);

    typedef enum logic [0:0] {ST_INIT, ST_RUN} pls_state_t;
endpackage : pls_pkg

/* File: logic/pls_top.sv */
module pls_top
    import pls_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Fuses, static
    input  wire logic        preset_default_option_i,
    input  wire logic        security_lock_fuse_i,
    // Tamper sense from the fuse mesh, asynchronous
    input  wire logic        tamper_i,
    // Avalon-MM slave
    input  wire logic [4:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    // Boundary-scan instruction port, same clock
    input  wire logic        tap_valid_i,
    input  wire logic [3:0]  tap_instr_i,
    output logic             tap_exec_o,
    output logic             tap_reject_o,
    // Local controls of the fabric cells
    input  wire logic [3:0]  local_clear_i,
    input  wire logic [3:0]  local_preset_i,
    // Global lines, networks, cells and probes
    output logic             global_clear_line_o,
    output logic             global_preset_line_o,
    output logic [3:0]       global_net_o,
    output logic [3:0]       cell_q_o,
    output logic [3:0]       probe_o
);

    pls_state_t  state_r, state_nxt;
    logic [3:0]  init_cnt_r, init_cnt_nxt;
    logic        global_clear_line_r, global_clear_line_nxt;
    logic        gpst_r, gpst_nxt;
    logic        pdef_r, lock_r;
    logic [2:0]  tamp_sync_r;
    logic        dead_r, dead_nxt;
    logic [15:0] ctrl_r, ctrl_nxt;
    logic [3:0]  cdata_r, cdata_nxt;
    logic [3:0]  cell_r, cell_nxt;
    logic [3:0]  probe_r, probe_nxt;
    logic        rej_r, rej_nxt;
    logic [31:0] prog_r, prog_nxt;
    logic [15:0] pcnt_r, pcnt_nxt;
    logic        ack_r, ack_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic        exec_r, exec_nxt;
    logic        trej_r, trej_nxt;
    logic        req, wr_go;
    logic        closed;
    logic        tap_priv;

    // The fuses are caught once at reset; they cannot change afterwards.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pdef_r <= preset_default_option_i;
            lock_r <= security_lock_fuse_i;
        end
    end

    // The tamper sense comes from outside the clock domain.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tamp_sync_r <= 3'h0;
        end else begin
            tamp_sync_r <= {tamp_sync_r[1:0], tamper_i};
        end
    end

    // Power-up sequencing of the global lines.
    always_comb begin
        state_nxt    = state_r;
        init_cnt_nxt = init_cnt_r;
        global_clear_line_nxt     = 1'b1;
        gpst_nxt     = 1'b1;
        case (state_r)
            ST_INIT: begin
                global_clear_line_nxt = pdef_r;
                gpst_nxt = ~pdef_r;
                // The lines stay asserted through the last count, so the pulse spans the full init length.
                if (init_cnt_r == INIT_LAST) begin
                    state_nxt = ST_RUN;
                end else begin
                    init_cnt_nxt = init_cnt_r + 4'h1;
                end
            end
            ST_RUN: begin
                global_clear_line_nxt = 1'b1;
                gpst_nxt = 1'b1;
            end
            default: state_nxt = ST_INIT;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r    <= ST_INIT;
            init_cnt_r <= 4'h0;
            global_clear_line_r     <= 1'b1;
            gpst_r     <= 1'b1;
        end else begin
            state_r    <= state_nxt;
            init_cnt_r <= init_cnt_nxt;
            global_clear_line_r     <= global_clear_line_nxt;
            gpst_r     <= gpst_nxt;
        end
    end

    // Fabric cells: each takes its enable from the global network that CTRL selects.
    generate
        for (genvar i = 0; i < PLS_NETS; i++) begin : g_cell
            logic [1:0] sel;
            assign sel = ctrl_r[PLS_CTRL_SEL_LSB + 2 * i +: 2];
            always_comb begin
                if (local_clear_i[i]) begin
                    cell_nxt[i] = 1'b0;
                end else if (local_preset_i[i]) begin
                    cell_nxt[i] = 1'b1;
                end else if (!global_clear_line_r) begin
                    cell_nxt[i] = 1'b0;
                end else if (!gpst_r) begin
                    cell_nxt[i] = 1'b1;
                end else if (ctrl_r[PLS_CTRL_GNET_LSB + sel]) begin
                    cell_nxt[i] = cdata_r[i];
                end else begin
                    cell_nxt[i] = cell_r[i];
                end
            end
        end
    endgenerate

    // Bus, probe, programming and boundary-scan logic.
    assign req      = avs_read_i | avs_write_i;
    // A write lands on the edge at which the master sees waitrequest low.
    assign wr_go    = avs_write_i & ack_r;
    assign closed   = lock_r | dead_r;
    assign tap_priv = tap_instr_i >= PLS_TAP_PRIV_FIRST;

    always_comb begin
        ack_nxt   = req & ~ack_r;
        rdata_nxt = rdata_r;
        ctrl_nxt  = ctrl_r;
        cdata_nxt = cdata_r;
        prog_nxt  = prog_r;
        pcnt_nxt  = pcnt_r;
        rej_nxt   = rej_r;
        dead_nxt  = dead_r | (tamp_sync_r[2] & tamp_sync_r[1]);
        exec_nxt  = 1'b0;
        trej_nxt  = 1'b0;
        if (avs_read_i && !ack_r) begin
            rdata_nxt = 32'h0000_0000;
            if (dead_r) begin
                rdata_nxt = {27'h0, 1'b1, 4'h0};
            end else if (avs_address_i == PLS_CTRL_ADDR) begin
                rdata_nxt = {16'h0, ctrl_r};
            end else if (avs_address_i == PLS_STATUS_ADDR) begin
                rdata_nxt = {27'h0, dead_r, pdef_r, lock_r, rej_r, state_r == ST_RUN};
            end else if (avs_address_i == PLS_CELL_ADDR) begin
                rdata_nxt = {24'h0, cell_r, cdata_r};
            end else if (avs_address_i == PLS_PCNT_ADDR) begin
                rdata_nxt = {16'h0, pcnt_r};
            end
        end
        // Clearing the reject flag is done first so that a same-cycle reject wins.
        if (wr_go && !dead_r) begin
            if (avs_address_i == PLS_CTRL_ADDR) begin
                ctrl_nxt = avs_writedata_i[15:0];
            end else if (avs_address_i == PLS_STATUS_ADDR) begin
                if (avs_writedata_i[PLS_ST_REJ_BIT]) begin
                    rej_nxt = 1'b0;
                end
            end else if (avs_address_i == PLS_CELL_ADDR) begin
                cdata_nxt = avs_writedata_i[3:0];
            end
        end
        if (wr_go && avs_address_i == PLS_PROG_ADDR) begin
            if (closed) begin
                rej_nxt = 1'b1;
            end else begin
                prog_nxt = avs_writedata_i;
                pcnt_nxt = pcnt_r + 16'h0001;
            end
        end
        if (tap_valid_i) begin
            if (dead_r || (lock_r && tap_priv)) begin
                trej_nxt = 1'b1;
                rej_nxt  = 1'b1;
            end else begin
                exec_nxt = 1'b1;
            end
        end
        // Probing shows cell states only while the part is open.
        probe_nxt = (ctrl_r[PLS_CTRL_PROBE_BIT] && !closed) ? cell_r : 4'h0;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r   <= 1'b0;
            rdata_r <= 32'h0000_0000;
            ctrl_r  <= PLS_CTRL_RST;
            cdata_r <= PLS_CELL_RST;
            cell_r  <= PLS_CELL_RST;
            prog_r  <= 32'h0000_0000;
            pcnt_r  <= 16'h0000;
            rej_r   <= 1'b0;
            dead_r  <= 1'b0;
            probe_r <= 4'h0;
            exec_r  <= 1'b0;
            trej_r  <= 1'b0;
        end else begin
            ack_r   <= ack_nxt;
            rdata_r <= rdata_nxt;
            ctrl_r  <= ctrl_nxt;
            cdata_r <= cdata_nxt;
            cell_r  <= cell_nxt;
            prog_r  <= prog_nxt;
            pcnt_r  <= pcnt_nxt;
            rej_r   <= rej_nxt;
            dead_r  <= dead_nxt;
            probe_r <= probe_nxt;
            exec_r  <= exec_nxt;
            trej_r  <= trej_nxt;
        end
    end

    assign avs_waitrequest_o    = req & ~ack_r;
    assign avs_readdata_o       = rdata_r;
    assign global_clear_line_o  = global_clear_line_r;
    assign global_preset_line_o = gpst_r;
    assign global_net_o         = ctrl_r[PLS_CTRL_GNET_LSB +: PLS_NETS];
    assign cell_q_o             = cell_r;
    assign probe_o              = probe_r;
    assign tap_exec_o           = exec_r;
    assign tap_reject_o         = trej_r;

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    init_clear_a: assert property ((state_r == ST_INIT && !pdef_r && init_cnt_r != INIT_LAST) |=>
        (!global_clear_line_r && gpst_r)) else $error("clear default not driven during init");
    init_preset_a: assert property ((state_r == ST_INIT && pdef_r && init_cnt_r != INIT_LAST) |=>
        (global_clear_line_r && !gpst_r)) else $error("preset default not driven during init");
    run_lines_a: assert property ((state_r == ST_RUN) |-> ##1 (global_clear_line_r && gpst_r)[*3])
        else $error("global lines not high in run");
    local_win_a: assert property (local_clear_i[0] |=> !cell_r[0])
        else $error("local clear lost to global line");
    probe_blank_a: assert property ((lock_r || dead_r) |=> probe_r == 4'h0)
        else $error("probe visible while locked");
    prog_refuse_a: assert property ((lock_r && wr_go && avs_address_i == PLS_PROG_ADDR) |=>
        ($stable(pcnt_r) && rej_r)) else $error("programming accepted while locked");
    tap_public_a: assert property ((tap_valid_i && !tap_priv && !dead_r) |=> tap_exec_o)
        else $error("public instruction not executed");
    tamper_dead_a: assert property (($rose(tamp_sync_r[2]) && tamp_sync_r[1]) |=> dead_r ##1 dead_r[*4])
        else $error("tamper did not kill access");
    init_len_a: assert property ($rose(state_r == ST_RUN) |-> $past(init_cnt_r) == INIT_LAST)
        else $error("init pulse length wrong");
    wait_bound_a: assert property (req |-> ##[0:1] !avs_waitrequest_o)
        else $error("bus answer late");
    net_load_a: assert property ((!local_clear_i[1] && !local_preset_i[1] && global_clear_line_r && gpst_r
        && ctrl_r[PLS_CTRL_GNET_LSB + ctrl_r[PLS_CTRL_SEL_LSB + 2 +: 2]]) |=> cell_r[1] == $past(cdata_r[1]))
        else $error("global network enable not honoured");

    init_done_c: cover property ($rose(state_r == ST_RUN));
    locked_tap_c: cover property (lock_r && tap_valid_i && tap_priv);
    prog_ok_c: cover property (!closed && wr_go && avs_address_i == PLS_PROG_ADDR);
    tamper_c: cover property ($rose(dead_r));

endmodule : pls_top

/* File: tb/pls_probe_model.sv */
module pls_probe_model (
    // Clock
    input  wire logic       clk_i,
    // Boundary-scan instruction issue
    output logic            tap_valid_o,
    output logic [3:0]      tap_instr_o,
    // Answer from the device
    input  wire logic       tap_exec_i,
    input  wire logic       tap_reject_i
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        tap_valid_o = 1'b0;
        tap_instr_o = 4'h0;
    end

    // The answer stands for one cycle only, so it is caught right after the edge that takes the code.
    task automatic send(input logic [3:0] code, output logic [1:0] ans);
        @(posedge clk_i);
        tap_valid_o <= 1'b1;
        tap_instr_o <= code;
        @(posedge clk_i);
        tap_valid_o <= 1'b0;
        tap_instr_o <= ~code;
        #1 ans = {tap_exec_i, tap_reject_i};
    endtask : send
endmodule : pls_probe_model

/* File: tb/powerup_init_and_security_lock_test.sv */
module powerup_init_and_security_lock_test;
    timeunit 1ns;
    timeprecision 1ps;
    import pls_pkg::*;

    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        pdef  = 1'b0;
    logic        lock  = 1'b0;
    logic        tamper = 1'b0;
    logic        rd    = 1'b0;
    logic        wr    = 1'b0;
    logic [4:0]  addr  = 5'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  lclr  = 4'h0;
    logic [3:0]  lpre  = 4'h0;
    logic [31:0] rdata;
    logic        wreq;
    logic        global_clear_line;
    logic        gpre;
    logic        tv;
    logic        te;
    logic        tr;
    logic [3:0]  ti;
    logic [3:0]  gnet;
    logic [3:0]  cq;
    logic [3:0]  probe;
    int          n_mismatch = 0;
    int          n_compared = 0;
    int          cyc = 0;

    always #20 clk_i = ~clk_i;

    pls_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .preset_default_option_i(pdef), .security_lock_fuse_i(lock),
        .tamper_i(tamper), .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
        .avs_readdata_o(rdata), .avs_waitrequest_o(wreq), .tap_valid_i(tv), .tap_instr_i(ti),
        .tap_exec_o(te), .tap_reject_o(tr), .local_clear_i(lclr), .local_preset_i(lpre),
        .global_clear_line_o(global_clear_line), .global_preset_line_o(gpre), .global_net_o(gnet), .cell_q_o(cq),
        .probe_o(probe));

    pls_probe_model partner_u (.clk_i(clk_i), .tap_valid_o(tv), .tap_instr_o(ti), .tap_exec_i(te),
        .tap_reject_i(tr));

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : report_and_stop

    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            report_and_stop();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", nm, e, g);
            n_mismatch++;
        end
    endtask : chk

    function automatic logic [3:0] exp_cell(input logic [3:0] c, input logic [3:0] p, input logic [3:0] d);
        return ~c & (p | d);
    endfunction : exp_cell

    // The request stands until the rising edge at which waitrequest is seen low; that edge also takes read data.
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        addr  <= a;
        wdata <= d;
        rd    <= ~w;
        wr    <= w;
        do begin
            @(posedge clk_i);
            n++;
        end while (wreq !== 1'b0);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        chk("wait_edges", 32'h2, n);
    endtask : bus

    task automatic do_reset(input logic p, input logic k);
        @(posedge clk_i);
        rst_i <= 1'b1;
        pdef <= p;
        lock <= k;
        tamper <= 1'b0;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (5) begin
            @(posedge clk_i);
            #1 chk("init_lines", {30'h0, p, ~p}, {30'h0, global_clear_line, gpre});
        end
        @(posedge clk_i);
        #1 chk("run_lines", 32'h3, {30'h0, global_clear_line, gpre});
        chk("init_cells", {28'h0, {4{p}}}, {28'h0, cq});
    endtask : do_reset

    initial begin
        logic [31:0] q;
        logic [1:0]  ans;
        logic [3:0]  n;
        logic [3:0]  c;
        logic [3:0]  p;
        logic [3:0]  d;
        void'($urandom(32'h47532597));
        do_reset(1'b0, 1'b0);
        bus(1'b0, PLS_STATUS_ADDR, 32'h0, q);
        chk("status", 32'h1, q);
        bus(1'b0, 5'h14, 32'h0, q);
        chk("unmapped", 32'h0, q);
        repeat (4) begin
            n = 4'($urandom);
            bus(1'b1, PLS_CTRL_ADDR, {28'h0, n}, q);
            #1 chk("global_net", {28'h0, n}, {28'h0, gnet});
        end
        // Net 0 high and every cell selecting it keeps all loads enabled.
        bus(1'b1, PLS_CTRL_ADDR, 32'h1f, q);
        repeat (8) begin
            c = 4'($urandom);
            p = 4'($urandom);
            d = 4'($urandom);
            bus(1'b1, PLS_CELL_ADDR, {28'h0, d}, q);
            lclr <= c;
            lpre <= p;
            repeat (2) @(posedge clk_i);
            #1 chk("cell", {28'h0, exp_cell(c, p, d)}, {28'h0, cq});
            chk("probe_open", {28'h0, exp_cell(c, p, d)}, {28'h0, probe});
            lclr <= 4'h0;
            lpre <= 4'h0;
        end
        bus(1'b1, PLS_PROG_ADDR, $urandom, q);
        bus(1'b1, PLS_PROG_ADDR, $urandom, q);
        bus(1'b0, PLS_PCNT_ADDR, 32'h0, q);
        chk("pcnt_open", 32'h2, q);
        partner_u.send(4'h9, ans);
        chk("tap_open", 32'h2, {30'h0, ans});
        do_reset(1'b1, 1'b1);
        // Fuse pins moving after reset must not reach the captured settings.
        lock <= 1'b0;
        pdef <= 1'b0;
        bus(1'b1, PLS_CTRL_ADDR, 32'h1f, q);
        bus(1'b1, PLS_CELL_ADDR, 32'hf, q);
        repeat (3) @(posedge clk_i);
        #1 chk("probe_locked", 32'h0, {28'h0, probe});
        bus(1'b1, PLS_PROG_ADDR, $urandom, q);
        bus(1'b0, PLS_PCNT_ADDR, 32'h0, q);
        chk("pcnt_locked", 32'h0, q);
        bus(1'b0, PLS_STATUS_ADDR, 32'h0, q);
        chk("status_locked", 32'hf, q);
        for (int i = 0; i < 16; i++) begin
            partner_u.send(4'(i), ans);
            chk("tap_locked", (i >= 8) ? 32'h1 : 32'h2, {30'h0, ans});
        end
        bus(1'b1, PLS_STATUS_ADDR, 32'h2, q);
        bus(1'b0, PLS_STATUS_ADDR, 32'h0, q);
        chk("status_clear", 32'hd, q);
        tamper <= 1'b1;
        repeat (6) @(posedge clk_i);
        bus(1'b0, PLS_CTRL_ADDR, 32'h0, q);
        chk("dead_read", 32'h10, q);
        partner_u.send(4'h1, ans);
        chk("tap_dead", 32'h1, {30'h0, ans});
        report_and_stop();
    end
endmodule : powerup_init_and_security_lock_test
